// ### rtl/coa_consts.svh
// Widths, reset values and address steps of the operand addressing block
`ifndef COA_CONSTS_SVH
`define COA_CONSTS_SVH
`define COA_ADDR_W    20
`define COA_IX_W      16
`define COA_OFS_W     8
`define COA_DISP_W    16
`define COA_LEN_W     3
`define COA_DATA_W    16
`define COA_TP_RST    20'h00000
`define COA_PTR_RST   20'h00000
`define COA_IX_RST    16'h0000
`define COA_DATA_RST  16'h0000
`define COA_HI_STEP   20'h00002
`define COA_HI_PAD    12'h000
`define COA_BE_ALL    2'h3
`define COA_BE_LO     2'h1
`define COA_BE_RST    2'h0
`define COA_SHORT_BK  20'h00080
`endif

// ### rtl/coa_ea_gen.sv
// Effective address and index update for memory operands
`timescale 1ns/100ps
`default_nettype none
`include "coa_consts.svh"
module coa_ea_gen import coa_pkg::*; (
	input  wire logic [`COA_ADDR_W-1:0] i_base,
	input  wire logic [`COA_IX_W-1:0]   i_ix,
	input  wire logic [`COA_OFS_W-1:0]  i_offset,
	input  wire coa_mode_t              i_mode,
	input  wire coa_size_t              i_size,
	output logic [`COA_ADDR_W-1:0]      o_ea,
	output logic [`COA_IX_W-1:0]        o_ix_next
);
	logic [`COA_ADDR_W-1:0] ofs_ext;
	logic [`COA_ADDR_W-1:0] ix_ext;

	always_comb begin
		ofs_ext   = `COA_ADDR_W'(signed'(i_offset));
		ix_ext    = `COA_ADDR_W'(i_ix);
		o_ix_next = i_ix;
		case (i_mode)
			MODE_BASED: begin
				o_ea = i_base;
			end
			MODE_OFFSET: begin
				o_ea = i_base + ofs_ext;
			end
			MODE_INDEXED: begin
				o_ea = i_base + ix_ext;
			end
			MODE_POSTINC: begin
				o_ea      = i_base + ix_ext;
				o_ix_next = i_ix + `COA_IX_W'(i_size);
			end
			default: begin
				o_ea = i_base;
			end
		endcase
	end
endmodule
`default_nettype wire

// ### rtl/coa_pkg.sv
// Types shared by the operand addressing block
package coa_pkg;
`include "coa_consts.svh"
	typedef enum logic [1:0] {
		MODE_BASED   = 2'h0,
		MODE_OFFSET  = 2'h1,
		MODE_INDEXED = 2'h2,
		MODE_POSTINC = 2'h3
	} coa_mode_t;
	// Code equals the index step of the operand size
	typedef enum logic [1:0] {
		SIZE_BYTE = 2'h1,
		SIZE_WORD = 2'h2,
		SIZE_PTR  = 2'h3
	} coa_size_t;
	typedef enum logic [1:0] {
		PTR_A  = 2'h0,
		PTR_B  = 2'h1,
		PTR_C  = 2'h2,
		PTR_PB = 2'h3
	} coa_ptr_t;
	typedef enum logic [1:0] {
		OP_ACCESS  = 2'h0,
		OP_JUMP    = 2'h1,
		OP_CALL    = 2'h2,
		OP_POINTER_MOVE_OP_TP = 2'h3
	} coa_op_t;
	typedef enum logic [4:0] {
		ST_IDLE  = 5'h01,
		ST_WR_LO = 5'h02,
		ST_WR_HI = 5'h04,
		ST_RD_LO = 5'h08,
		ST_RD_HI = 5'h10
	} coa_state_t;
endpackage

// ### rtl/coa_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module coa_sync (
	input  wire logic i_clk,
	input  wire logic i_rstn,
	input  wire logic i_pin,
	output logic      o_level
);
	logic s1;
	logic s2;
	logic s3;
	logic next_level;

	// Change counts only once stages two and three agree
	always_comb begin
		next_level = (s2 == s3) ? s3 : o_level;
	end

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			s1      <= 1'b0;
			s2      <= 1'b0;
			s3      <= 1'b0;
			o_level <= 1'b0;
		end else begin
			s1      <= i_pin;
			s2      <= s1;
			s3      <= s2;
			o_level <= next_level;
		end
	end
endmodule
`default_nettype wire

// ### rtl/coa_top.sv
// Operand addressing, program transfer and task pointer save/restore
//
// How it works
// - Based: selected pointer is the address
// - Offset: pointer plus signed 8-bit offset
// - Indexed: pointer plus index, index kept
// - Post-increment: index grows by 1/2/3 after
// - Transfer adds displacement to task pointer
// - Displacement counts from instruction end
// - Short form one byte, long two
// - Call saves return address (task pointer plus instruction length), then jumps
// - Pointer move reloads task pointer from memory
// - Suspend saves task pointer at parameter block
`timescale 1ns/100ps
`default_nettype none
`include "coa_consts.svh"
module coa_top import coa_pkg::*; (
	input  wire logic                   i_clk,
	input  wire logic                   i_rstn,
	input  wire logic                   i_req,
	input  wire coa_op_t                i_op,
	input  wire coa_mode_t              i_mode,
	input  wire coa_ptr_t               i_ptr_sel,
	input  wire logic [`COA_OFS_W-1:0]  i_offset,
	input  wire coa_size_t              i_size,
	input  wire logic [`COA_DISP_W-1:0] i_disp,
	input  wire logic                   i_disp_long,
	input  wire logic [`COA_LEN_W-1:0]  i_instr_len,
	input  wire logic                   i_ptr_wr,
	input  wire coa_ptr_t               i_ptr_wr_sel,
	input  wire logic [`COA_ADDR_W-1:0] i_ptr_wr_data,
	input  wire logic                   i_ix_wr,
	input  wire logic [`COA_IX_W-1:0]   i_ix_wr_data,
	input  wire logic                   i_tp_wr,
	input  wire logic [`COA_ADDR_W-1:0] i_tp_wr_data,
	input  wire logic                   i_suspend,
	input  wire logic                   i_mem_ack,
	input  wire logic [`COA_DATA_W-1:0] i_mem_rdata,
	output logic                        o_mem_req,
	output logic                        o_mem_we,
	output logic [`COA_ADDR_W-1:0]      o_mem_addr,
	output logic [`COA_DATA_W-1:0]      o_mem_wdata,
	output logic [1:0]                  o_mem_be,
	output logic                        o_busy,
	output logic                        o_done,
	output logic                        o_susp_done,
	output logic [`COA_ADDR_W-1:0]      o_ea,
	output logic [`COA_ADDR_W-1:0]      o_task_pointer,
	output logic [`COA_IX_W-1:0]        o_index_register
);
	// ****************************************
	// Reset release
	// ****************************************
	logic rst_meta;
	logic rst_n;

	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// ****************************************
	// Pointer registers
	// ****************************************
	logic [`COA_ADDR_W-1:0] ptr [4];

	for (genvar g = 0; g < 4; g++) begin : g_ptr
		logic [`COA_ADDR_W-1:0] next_ptr;
		always_comb begin
			next_ptr = (i_ptr_wr && i_ptr_wr_sel == coa_ptr_t'(g)) ? i_ptr_wr_data : ptr[g];
		end
		always_ff @(posedge i_clk or negedge rst_n) begin
			if (!rst_n) begin
				ptr[g] <= `COA_PTR_RST;
			end else begin
				ptr[g] <= next_ptr;
			end
		end
	end

	// ****************************************
	// Suspend pin
	// ****************************************
	logic susp_lvl;
	logic susp_prev;
	logic susp_pend;
	logic susp_rise;
	logic next_susp_pend;

	coa_sync u_sync (
		.i_clk   (i_clk),
		.i_rstn  (rst_n),
		.i_pin   (i_suspend),
		.o_level (susp_lvl)
	);

	assign susp_rise = susp_lvl && !susp_prev;

	// ****************************************
	// Address arithmetic
	// ****************************************
	logic [`COA_ADDR_W-1:0] ea_calc;
	logic [`COA_IX_W-1:0]   ix_calc;
	logic [`COA_ADDR_W-1:0] disp_ext;
	logic [`COA_ADDR_W-1:0] end_addr;
	logic                   taken;

	coa_ea_gen u_ea (
		.i_base    (ptr[i_ptr_sel]),
		.i_ix      (o_index_register),
		.i_offset  (i_offset),
		.i_mode    (i_mode),
		.i_size    (i_size),
		.o_ea      (ea_calc),
		.o_ix_next (ix_calc)
	);

	// Short form sign-extends so backward targets work
	assign disp_ext = i_disp_long ? `COA_ADDR_W'(signed'(i_disp)) :
		`COA_ADDR_W'(signed'(i_disp[7:0]));
	assign end_addr = o_task_pointer + `COA_ADDR_W'(i_instr_len);

	// ****************************************
	// Sequencer
	// ****************************************
	coa_state_t             state;
	coa_state_t             next_state;
	logic [`COA_ADDR_W-1:0] ret_addr;
	logic [`COA_ADDR_W-1:0] next_ret_addr;
	logic [`COA_ADDR_W-1:0] target;
	logic [`COA_ADDR_W-1:0] next_target;
	logic [`COA_DATA_W-1:0] rd_lo;
	logic [`COA_DATA_W-1:0] next_rd_lo;
	logic                   is_susp;
	logic                   next_is_susp;
	logic [`COA_ADDR_W-1:0] next_tp;
	logic [`COA_IX_W-1:0]   next_ix;
	logic [`COA_ADDR_W-1:0] next_ea;
	logic                   next_mem_req;
	logic                   next_mem_we;
	logic [`COA_ADDR_W-1:0] next_mem_addr;
	logic [`COA_DATA_W-1:0] next_mem_wdata;
	logic [1:0]             next_mem_be;
	logic                   next_done;
	logic                   next_susp_done;

	// Suspend beats a new request so the save is never delayed twice
	assign taken = (state == ST_IDLE) && !susp_pend && i_req;

	always_comb begin
		next_state     = state;
		next_ret_addr  = ret_addr;
		next_target    = target;
		next_rd_lo     = rd_lo;
		next_is_susp   = is_susp;
		next_tp        = i_tp_wr ? i_tp_wr_data : o_task_pointer;
		next_ix        = i_ix_wr ? i_ix_wr_data : o_index_register;
		next_ea        = o_ea;
		next_mem_req   = o_mem_req;
		next_mem_we    = o_mem_we;
		next_mem_addr  = o_mem_addr;
		next_mem_wdata = o_mem_wdata;
		next_mem_be    = o_mem_be;
		next_done      = 1'b0;
		next_susp_done = 1'b0;
		next_susp_pend = susp_pend || susp_rise;
		case (state)
			ST_IDLE: begin
				if (susp_pend) begin
					next_susp_pend = susp_rise;
					next_is_susp   = 1'b1;
					next_ret_addr  = o_task_pointer;
					next_mem_addr  = ptr[PTR_PB];
					next_mem_wdata = o_task_pointer[15:0];
					next_mem_be    = `COA_BE_ALL;
					next_mem_we    = 1'b1;
					next_mem_req   = 1'b1;
					next_state     = ST_WR_LO;
				end else if (i_req) begin
					case (i_op)
						OP_ACCESS: begin
							next_ea   = ea_calc;
							next_ix   = ix_calc;
							next_done = 1'b1;
						end
						OP_JUMP: begin
							next_tp   = end_addr + disp_ext;
							next_done = 1'b1;
						end
						OP_CALL: begin
							next_ea        = ea_calc;
							next_ix        = ix_calc;
							next_ret_addr  = end_addr;
							next_target    = end_addr + disp_ext;
							next_mem_addr  = ea_calc;
							next_mem_wdata = end_addr[15:0];
							next_mem_be    = `COA_BE_ALL;
							next_mem_we    = 1'b1;
							next_mem_req   = 1'b1;
							next_state     = ST_WR_LO;
						end
						OP_POINTER_MOVE_OP_TP: begin
							next_ea       = ea_calc;
							next_ix       = ix_calc;
							next_mem_addr = ea_calc;
							next_mem_be   = `COA_BE_ALL;
							next_mem_we   = 1'b0;
							next_mem_req  = 1'b1;
							next_state    = ST_RD_LO;
						end
						default: begin
							next_done = 1'b1;
						end
					endcase
				end
			end
			ST_WR_LO: begin
				if (i_mem_ack) begin
					next_mem_addr  = o_mem_addr + `COA_HI_STEP;
					next_mem_wdata = {`COA_HI_PAD, ret_addr[19:16]};
					// Call pointer is three bytes, suspend area two words
					next_mem_be    = is_susp ? `COA_BE_ALL : `COA_BE_LO;
					next_state     = ST_WR_HI;
				end
			end
			ST_WR_HI: begin
				if (i_mem_ack) begin
					next_mem_req = 1'b0;
					next_mem_we  = 1'b0;
					next_mem_be  = `COA_BE_RST;
					next_is_susp = 1'b0;
					if (is_susp) begin
						next_susp_done = 1'b1;
					end else begin
						next_tp   = target;
						next_done = 1'b1;
					end
					next_state = ST_IDLE;
				end
			end
			ST_RD_LO: begin
				if (i_mem_ack) begin
					next_rd_lo    = i_mem_rdata;
					next_mem_addr = o_mem_addr + `COA_HI_STEP;
					next_mem_be   = `COA_BE_LO;
					next_state    = ST_RD_HI;
				end
			end
			ST_RD_HI: begin
				if (i_mem_ack) begin
					next_tp      = {i_mem_rdata[3:0], rd_lo};
					next_mem_req = 1'b0;
					next_mem_be  = `COA_BE_RST;
					next_done    = 1'b1;
					next_state   = ST_IDLE;
				end
			end
			default: begin
				next_state   = ST_IDLE;
				next_mem_req = 1'b0;
				next_mem_we  = 1'b0;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			state            <= ST_IDLE;
			ret_addr         <= `COA_TP_RST;
			target           <= `COA_TP_RST;
			rd_lo            <= `COA_DATA_RST;
			is_susp          <= 1'b0;
			susp_prev        <= 1'b0;
			susp_pend        <= 1'b0;
			o_task_pointer   <= `COA_TP_RST;
			o_index_register <= `COA_IX_RST;
			o_ea             <= `COA_PTR_RST;
			o_mem_req        <= 1'b0;
			o_mem_we         <= 1'b0;
			o_mem_addr       <= `COA_PTR_RST;
			o_mem_wdata      <= `COA_DATA_RST;
			o_mem_be         <= `COA_BE_RST;
			o_busy           <= 1'b0;
			o_done           <= 1'b0;
			o_susp_done      <= 1'b0;
		end else begin
			state            <= next_state;
			ret_addr         <= next_ret_addr;
			target           <= next_target;
			rd_lo            <= next_rd_lo;
			is_susp          <= next_is_susp;
			susp_prev        <= susp_lvl;
			susp_pend        <= next_susp_pend;
			o_task_pointer   <= next_tp;
			o_index_register <= next_ix;
			o_ea             <= next_ea;
			o_mem_req        <= next_mem_req;
			o_mem_we         <= next_mem_we;
			o_mem_addr       <= next_mem_addr;
			o_mem_wdata      <= next_mem_wdata;
			o_mem_be         <= next_mem_be;
			o_busy           <= (next_state != ST_IDLE);
			o_done           <= next_done;
			o_susp_done      <= next_susp_done;
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	property p_based;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op == OP_ACCESS && i_mode == MODE_BASED |=> o_ea == $past(ptr[i_ptr_sel]);
	endproperty
	a_based: assert property (p_based) else $error("based address wrong");

	property p_offset;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op == OP_ACCESS && i_mode == MODE_OFFSET |=>
			o_ea == $past(ptr[i_ptr_sel] + `COA_ADDR_W'(signed'(i_offset)));
	endproperty
	a_offset: assert property (p_offset) else $error("offset address wrong");

	property p_indexed;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op == OP_ACCESS && i_mode == MODE_INDEXED && !i_ix_wr |=>
			o_ea == $past(ptr[i_ptr_sel] + `COA_ADDR_W'(o_index_register))
			&& $stable(o_index_register);
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong");

	property p_postinc;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op != OP_JUMP && i_mode == MODE_POSTINC |=>
			o_index_register == $past(o_index_register) + `COA_IX_W'($past(i_size));
	endproperty
	a_postinc: assert property (p_postinc) else $error("index step wrong");

	property p_jump;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op == OP_JUMP && !i_tp_wr |=> o_task_pointer == $past(end_addr + disp_ext);
	endproperty
	a_jump: assert property (p_jump) else $error("transfer target wrong");

	property p_zero_disp;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op == OP_JUMP && i_disp == `COA_DATA_RST |=> o_task_pointer == $past(end_addr);
	endproperty
	a_zero_disp: assert property (p_zero_disp) else $error("zero transfer not next");

	property p_short_back;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op == OP_JUMP && !i_disp_long && i_disp[7] |=>
			($past(end_addr) - o_task_pointer) <= `COA_SHORT_BK && o_task_pointer != $past(end_addr);
	endproperty
	a_short_back: assert property (p_short_back) else $error("short jump not back");

	property p_call_save;
		@(posedge i_clk) disable iff (!rst_n)
		taken && i_op == OP_CALL && !i_tp_wr |=> o_mem_req && o_mem_we
			&& o_mem_wdata == $past(end_addr[15:0]) && $stable(o_task_pointer);
	endproperty
	a_call_save: assert property (p_call_save) else $error("call save missing");

	property p_pointer_move_op;
		@(posedge i_clk) disable iff (!rst_n)
		state == ST_RD_HI && i_mem_ack |=> o_done
			&& o_task_pointer == {$past(i_mem_rdata[3:0]), $past(rd_lo)};
	endproperty
	a_pointer_move_op: assert property (p_pointer_move_op) else $error("pointer reload wrong");

	property p_susp;
		@(posedge i_clk) disable iff (!rst_n)
		state == ST_IDLE && susp_pend |=> o_mem_req && o_mem_we
			&& o_mem_addr == $past(ptr[PTR_PB]) && o_mem_wdata == $past(o_task_pointer[15:0]);
	endproperty
	a_susp: assert property (p_susp) else $error("suspend save wrong");
endmodule
`default_nettype wire

// ### test/coa_mem_model.sv
// Memory partner model: word store with byte enables, prompt or slow answer
`timescale 1ns/100ps
`default_nettype none
`include "coa_consts.svh"
module coa_mem_model (
	input  wire logic                   i_clk,
	input  wire logic                   i_rstn,
	input  wire logic                   i_slow,
	input  wire logic                   i_req,
	input  wire logic                   i_we,
	input  wire logic [`COA_ADDR_W-1:0] i_addr,
	input  wire logic [`COA_DATA_W-1:0] i_wdata,
	input  wire logic [1:0]             i_be,
	output logic                        o_ack,
	output logic [`COA_DATA_W-1:0]      o_rdata
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] word;
	logic [2:0]  cnt;
	// ************************
	// Answer logic
	// ************************
	// Read data toggles when idle and after each answer so stale data never looks valid
	always @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_ack <= 1'b0;
			o_rdata <= 16'h0000;
			cnt <= 3'h0;
		end else if (o_ack) begin
			o_ack <= 1'b0;
			o_rdata <= ~o_rdata;
			cnt <= 3'h0;
			if (i_we) begin
				word = mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
				if (i_be[0]) word[7:0] = i_wdata[7:0];
				if (i_be[1]) word[15:8] = i_wdata[15:8];
				mem[i_addr] = word;
			end
		end else if (i_req) begin
			if (!i_slow || cnt == 3'h3) begin
				o_ack <= 1'b1;
				o_rdata <= mem.exists(i_addr) ? mem[i_addr] : 16'h0000;
			end else begin
				cnt <= cnt + 3'h1;
			end
		end else begin
			o_rdata <= ~o_rdata;
		end
	end
endmodule
`default_nettype wire

// ### test/tb_channel_operand_addressing.sv
// Self-checking bench for operand addressing and program transfer
`timescale 1ns/100ps
`default_nettype none
`include "coa_consts.svh"
module tb_channel_operand_addressing import coa_pkg::*;;
	logic i_clk, i_rstn, i_req, i_disp_long, i_ptr_wr, i_ix_wr, i_tp_wr, i_suspend, slow;
	coa_op_t     i_op;
	coa_mode_t   i_mode;
	coa_ptr_t    i_ptr_sel, i_ptr_wr_sel;
	coa_size_t   i_size;
	logic [7:0]  i_offset;
	logic [15:0] i_disp, i_ix_wr_data, i_mem_rdata, o_mem_wdata, o_index_register;
	logic [2:0]  i_instr_len;
	logic [19:0] i_ptr_wr_data, i_tp_wr_data, o_mem_addr, o_ea, o_task_pointer;
	logic        i_mem_ack, o_mem_req, o_mem_we, o_busy, o_done, o_susp_done;
	logic [1:0]  o_mem_be;
	integer      num_errors, n_tests;
	logic [19:0] ptrs [4] = '{20'h10000, 20'h20100, 20'h30200, 20'h40300};
	logic [19:0] exp_task_ptr;
	logic [15:0] exp_idx;

	coa_top coa_top_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_req(i_req), .i_op(i_op),
		.i_mode(i_mode), .i_ptr_sel(i_ptr_sel), .i_offset(i_offset), .i_size(i_size),
		.i_disp(i_disp), .i_disp_long(i_disp_long), .i_instr_len(i_instr_len),
		.i_ptr_wr(i_ptr_wr), .i_ptr_wr_sel(i_ptr_wr_sel), .i_ptr_wr_data(i_ptr_wr_data),
		.i_ix_wr(i_ix_wr), .i_ix_wr_data(i_ix_wr_data), .i_tp_wr(i_tp_wr),
		.i_tp_wr_data(i_tp_wr_data), .i_suspend(i_suspend), .i_mem_ack(i_mem_ack),
		.i_mem_rdata(i_mem_rdata), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
		.o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .o_mem_be(o_mem_be),
		.o_busy(o_busy), .o_done(o_done), .o_susp_done(o_susp_done), .o_ea(o_ea),
		.o_task_pointer(o_task_pointer), .o_index_register(o_index_register));

	coa_mem_model coa_mem_model_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_slow(slow),
		.i_req(o_mem_req), .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata),
		.i_be(o_mem_be), .o_ack(i_mem_ack), .o_rdata(i_mem_rdata));

	always #50 i_clk = ~i_clk;

	// ************************
	// Shared tasks
	// ************************
	task test_done;
		$display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task chk(input string name, input logic [19:0] seen, input logic [19:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Save must not disturb the task pointer before the sequence ends
	task run(input coa_op_t op, input coa_mode_t m, input coa_ptr_t p, input logic [7:0] ofs,
		input coa_size_t sz, input logic [15:0] d, input logic lg, input logic [2:0] len);
		integer k;
		@(posedge i_clk);
		i_req <= 1'b1;
		i_op <= op;
		i_mode <= m;
		i_ptr_sel <= p;
		i_offset <= ofs;
		i_size <= sz;
		i_disp <= d;
		i_disp_long <= lg;
		i_instr_len <= len;
		@(posedge i_clk);
		i_req <= 1'b0;
		#1;
		for (k = 0; k < 40 && o_done !== 1'b1; k++) begin
			if (o_busy === 1'b1) chk("busy_task_ptr", o_task_pointer, exp_task_ptr);
			@(posedge i_clk);
			#1;
		end
		if (o_done !== 1'b1) begin
			num_errors++;
			test_done();
		end
	endtask

	task set_regs;
		integer i;
		for (i = 0; i < 4; i++) begin
			@(posedge i_clk);
			i_ptr_wr <= 1'b1;
			i_ptr_wr_sel <= coa_ptr_t'(i);
			i_ptr_wr_data <= ptrs[i];
		end
		i_ix_wr <= 1'b1;
		i_tp_wr <= 1'b1;
		@(posedge i_clk);
		i_ptr_wr <= 1'b0;
		i_ix_wr <= 1'b0;
		i_tp_wr <= 1'b0;
	endtask

	// ************************
	// Scenarios
	// ************************
	task t_modes;
		integer p, m;
		logic [19:0] ea;
		logic [7:0]  ofs;
		coa_size_t   sz;
		for (p = 0; p < 4; p++) begin
			for (m = 0; m < 4; m++) begin
				ofs = p[0] ? 8'h80 : 8'h7F;
				sz = coa_size_t'(p % 3 + 1);
				case (m)
					0: ea = ptrs[p];
					1: ea = ptrs[p] + {{12{ofs[7]}}, ofs};
					default: ea = ptrs[p] + {4'h0, exp_idx};
				endcase
				run(OP_ACCESS, coa_mode_t'(m), coa_ptr_t'(p), ofs, sz, 16'h0000, 1'b0, 3'h0);
				if (m == 3) exp_idx = exp_idx + {14'h0000, sz};
				chk("ea", o_ea, ea);
				chk("index", {4'h0, o_index_register}, {4'h0, exp_idx});
			end
		end
	endtask

	// Long entries carry low bytes that would mislead a short-form adder
	task t_jumps;
		integer i;
		logic [15:0] jd [5];
		logic [4:0]  jl;
		logic [19:0] sx;
		jd = '{16'h0080, 16'h007F, 16'h0000, 16'hFF00, 16'h0123};
		jl = 5'h18;
		for (i = 0; i < 5; i++) begin
			sx = jl[i] ? {{4{jd[i][15]}}, jd[i]} : {{12{jd[i][7]}}, jd[i][7:0]};
			run(OP_JUMP, MODE_BASED, PTR_A, 8'h00, SIZE_BYTE, jd[i], jl[i], 3'(i + 2));
			exp_task_ptr = exp_task_ptr + 20'(i + 2) + sx;
			chk("jump_task_ptr", o_task_pointer, exp_task_ptr);
		end
	endtask

	task t_call;
		logic [19:0] ret;
		slow = 1'b1;
		ret = exp_task_ptr + 20'h00004;
		run(OP_CALL, MODE_BASED, PTR_C, 8'h00, SIZE_PTR, 16'h00F0, 1'b0, 3'h4);
		exp_task_ptr = ret + 20'hFFFF0;
		chk("save_lo", {4'h0, coa_mem_model_i.mem[20'h30200]}, {4'h0, ret[15:0]});
		chk("save_hi", {4'h0, coa_mem_model_i.mem[20'h30202]}, {12'h0FF, 4'h0, ret[19:16]});
		chk("call_task_ptr", o_task_pointer, exp_task_ptr);
		slow = 1'b0;
		run(OP_POINTER_MOVE_OP_TP, MODE_BASED, PTR_C, 8'h00, SIZE_PTR, 16'h0000, 1'b0, 3'h0);
		exp_task_ptr = ret;
		chk("return_task_ptr", o_task_pointer, ret);
	endtask

	task t_susp;
		integer k;
		@(posedge i_clk);
		i_suspend <= 1'b1;
		for (k = 0; k < 40 && o_susp_done !== 1'b1; k++) begin
			@(posedge i_clk);
			#1;
		end
		if (o_susp_done !== 1'b1) begin
			num_errors++;
			test_done();
		end
		chk("susp_lo", {4'h0, coa_mem_model_i.mem[20'h40300]}, {4'h0, exp_task_ptr[15:0]});
		chk("susp_hi", {4'h0, coa_mem_model_i.mem[20'h40302]}, {16'h0000, exp_task_ptr[19:16]});
		chk("susp_task_ptr", o_task_pointer, exp_task_ptr);
		@(posedge i_clk);
		i_suspend <= 1'b0;
	endtask

	// ************************
	// Main sequence
	// ************************
	initial begin
		{i_clk, i_req, i_disp_long, i_ptr_wr, i_ix_wr, i_tp_wr, i_suspend, slow} = 8'h00;
		i_rstn = 1'b0;
		i_op = OP_ACCESS;
		i_mode = MODE_BASED;
		i_ptr_sel = PTR_A;
		i_ptr_wr_sel = PTR_A;
		i_size = SIZE_BYTE;
		i_offset = 8'h00;
		i_disp = 16'h0000;
		i_instr_len = 3'h0;
		i_ptr_wr_data = 20'h00000;
		i_ix_wr_data = 16'h0004;
		i_tp_wr_data = 20'h05000;
		exp_idx = 16'h0004;
		exp_task_ptr = 20'h05000;
		num_errors = 0;
		n_tests = 0;
		coa_mem_model_i.mem[20'h30202] = 16'hFFFF;
		coa_mem_model_i.mem[20'h40302] = 16'hFFFF;
		repeat (5) @(posedge i_clk);
		i_rstn <= 1'b1;
		repeat (3) @(posedge i_clk);
		set_regs();
		t_modes();
		t_jumps();
		t_call();
		t_susp();
		test_done();
	end
endmodule
`default_nettype wire
